// [verilog/sbs_sequencer.sv]
`timescale 1ns/1ps
module sbs_sequencer import sbs_pkg::*; #(
  parameter int unsigned TENTH_CYCLES = TENTH_CYC
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  sbs_bus_t              bus,
  output logic [31:0]           rdata,
  input  sbs_meas_t             meas,
  input  wire logic             measUpdate,
  input  wire logic             batchStartSignal_n,
  input  wire logic             batchRunEnable_n,
  input  wire logic             batchStopInput_n,
  input  wire logic             batchResetInput_n,
  output logic [NSP-1:0]        spOut,
  output logic                  batchActive
);

  // pin index within the synchroniser vectors
  localparam int PIN_START = 0;
  localparam int PIN_RUN   = 1;
  localparam int PIN_STOP  = 2;
  localparam int PIN_RESET = 3;

  logic [3:0]       pinSync1_q;
  logic [3:0]       pinSync2_q;
  logic [3:0]       pinPrev_q;
  logic [3:0]       pinFall;

  logic [2:0]       ctrl_q;
  logic [2:0]       ctrl_d;
  sbs_cfg_t         cfg_q [NSP];
  sbs_cfg_t         cfg_d [NSP];
  logic [31:0]      val_q [NSP];
  logic [31:0]      val_d [NSP];

  sbs_state_t       state_q;
  sbs_state_t       state_d;
  logic [4:0]       ptr_q;
  logic [4:0]       ptr_d;
  logic [NSP-1:0]   doneMask_q;
  logic [NSP-1:0]   doneMask_d;
  logic             advance;

  logic [NSP-1:0]   spOut_q;
  logic [NSP-1:0]   spOut_d;
  logic             batchActive_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;

  logic [NSP-1:0]   hit;
  logic [NSP-1:0]   isCmp;
  logic [NSP-1:0]   isBatch;
  logic [NSP-1:0]   isFree;
  logic [5:0]       firstStep;
  logic [5:0]       nextStep;
  logic             startEv;
  logic             stopEv;
  logic             resetEv;
  logic             runBlocked;
  logic             cmdWrite;
  logic [4:0]       cfgIdx;
  logic [4:0]       valIdx;
  sbs_kind_t        curKind;
  logic             delayRun;
  logic             delayDone;

  // returns {found, index} of the first batch step after 'from' (or at it when incl)
  function automatic logic [5:0] findStep(logic [NSP-1:0] mask, logic [4:0] from, logic incl);
    logic [5:0] res;
    res = 6'h00;
    for (int j = NSP - 1; j >= 0; j--) begin
      if (mask[j] && ((j > int'(from)) || (incl && (j == int'(from))))) begin
        res = {1'b1, 5'(j)};
      end
    end
    return res;
  endfunction

  // pins are asynchronous to clk; only the second stage and its one-cycle-delayed copy are looked at
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_q <= 4'hF;
      pinSync2_q <= 4'hF;
      pinPrev_q  <= 4'hF;
    end else begin
      pinSync1_q <= {batchResetInput_n, batchStopInput_n, batchRunEnable_n, batchStartSignal_n};
      pinSync2_q <= pinSync1_q;
      pinPrev_q  <= pinSync2_q;
    end
  end

  // inputs are active low: an event is the falling edge
  assign pinFall = pinPrev_q & ~pinSync2_q;

  assign cmdWrite = bus.wr && (bus.addr == ADDR_CMD);
  assign startEv  = pinFall[PIN_START] || (cmdWrite && bus.wdata[CMD_START_BIT]);
  assign stopEv   = pinFall[PIN_STOP] || (cmdWrite && bus.wdata[CMD_STOP_BIT]);
  assign resetEv  = pinFall[PIN_RESET] || (cmdWrite && bus.wdata[CMD_RESET_BIT]);
  // an unassigned run input behaves as permanently low
  assign runBlocked = ctrl_q[CTRL_RUNASG_BIT] && pinSync2_q[PIN_RUN];

  assign cfgIdx = 5'(bus.addr - ADDR_CFG_BASE);
  assign valIdx = 5'(bus.addr - ADDR_VAL_BASE);

  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d  = cfg_q;
    val_d  = val_q;
    if (bus.wr) begin
      if (bus.addr == ADDR_CTRL) begin
        ctrl_d = bus.wdata[2:0];
      end else if (bus.addr >= ADDR_CFG_BASE && bus.addr <= ADDR_CFG_LAST) begin
        cfg_d[cfgIdx].batchSeq   = bus.wdata[5];
        cfg_d[cfgIdx].tripHigher = bus.wdata[4];
        // undefined kind codes are stored as off so they can never trip
        cfg_d[cfgIdx].kind = (bus.wdata[3:0] > KIND_DELAY) ? KIND_OFF : sbs_kind_t'(bus.wdata[3:0]);
      end else if (bus.addr >= ADDR_VAL_BASE && bus.addr <= ADDR_VAL_LAST) begin
        val_d[valIdx] = bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
      for (int k = 0; k < NSP; k++) begin
        cfg_q[k] <= CFG_RST;
        val_q[k] <= VAL_RST;
      end
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
      val_q  <= val_d;
    end
  end

  for (genvar i = 0; i < NSP; i++) begin : g_sp
    logic avail;
    logic isStep;

    sbs_compare u_cmp (
      .cfg   (cfg_q[i]),
      .value (val_q[i]),
      .meas  (meas),
      .hit   (hit[i])
    );

    assign avail  = !((i == NSP - 1) && ctrl_q[CTRL_PLC_BIT]);
    assign isCmp[i] = cfg_q[i].kind != KIND_OFF && cfg_q[i].kind != KIND_PAUSE
                      && cfg_q[i].kind != KIND_DELAY;
    assign isStep = cfg_q[i].kind == KIND_PAUSE || cfg_q[i].kind == KIND_DELAY;
    assign isBatch[i] = avail && ctrl_q[CTRL_BATCH_BIT]
                        && (isStep || (isCmp[i] && cfg_q[i].batchSeq));
    assign isFree[i]  = avail && isCmp[i] && !isBatch[i];

    always_comb begin
      if (isFree[i]) begin
        spOut_d[i] = measUpdate ? hit[i] : spOut_q[i];
      end else if (isBatch[i] && isCmp[i]) begin
        // a step drives only while current, running and not yet satisfied
        spOut_d[i] = (state_q == ST_RUN) && (ptr_q == 5'(i)) && !doneMask_q[i];
      end else begin
        spOut_d[i] = 1'b0;
      end
    end
  end

  assign firstStep = findStep(isBatch, 5'h00, 1'b1);
  assign nextStep  = findStep(isBatch, ptr_q, 1'b0);
  assign curKind   = cfg_q[ptr_q].kind;
  assign delayRun  = (state_q == ST_RUN) && isBatch[ptr_q] && (curKind == KIND_DELAY);

  sbs_delay #(
    .TICK_CYC (TENTH_CYCLES)
  ) u_delay (
    .clk    (clk),
    .arst_n (arst_n),
    .clear  (advance),
    .run    (delayRun),
    .tenths (val_q[ptr_q]),
    .done   (delayDone)
  );

  always_comb begin
    state_d    = state_q;
    ptr_d      = ptr_q;
    doneMask_d = doneMask_q;
    advance    = 1'b0;
    if (!ctrl_q[CTRL_BATCH_BIT]) begin
      state_d    = ST_IDLE;
      ptr_d      = 5'h00;
      doneMask_d = '0;
    end else if (resetEv) begin
      state_d    = ST_IDLE;
      ptr_d      = firstStep[4:0];
      doneMask_d = '0;
    end else if (stopEv) begin
      if (state_q == ST_RUN || state_q == ST_PAUSED) begin
        state_d = ST_STOPPED;
      end
    end else if (state_q == ST_RUN && runBlocked) begin
      state_d = ST_STOPPED;
    end else if (startEv) begin
      if (runBlocked) begin
        state_d    = ST_IDLE;
        ptr_d      = firstStep[4:0];
        doneMask_d = '0;
      end else begin
        case (state_q)
          ST_IDLE, ST_DONE: begin
            doneMask_d = '0;
            ptr_d      = firstStep[4:0];
            state_d    = firstStep[5] ? ST_RUN : ST_DONE;
          end
          ST_PAUSED:  advance = 1'b1;
          ST_STOPPED: state_d = ST_RUN;
          default:    state_d = state_q;
        endcase
      end
    end else if (state_q == ST_RUN) begin
      if (!isBatch[ptr_q]) begin
        // configuration changed under the pointer: skip the entry
        advance = 1'b1;
      end else if (curKind == KIND_PAUSE) begin
        state_d = ST_PAUSED;
      end else if (curKind == KIND_DELAY) begin
        advance = delayDone;
      end else if (measUpdate && hit[ptr_q]) begin
        doneMask_d[ptr_q] = 1'b1;
        advance = 1'b1;
      end
    end
    if (advance) begin
      if (nextStep[5]) begin
        ptr_d   = nextStep[4:0];
        state_d = ST_RUN;
      end else begin
        state_d = ST_DONE;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      ptr_q      <= 5'h00;
      doneMask_q <= '0;
    end else begin
      state_q    <= state_d;
      ptr_q      <= ptr_d;
      doneMask_q <= doneMask_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bus.rd) begin
      if (bus.addr == ADDR_CTRL) begin
        rdata_d = {29'h0000_0000, ctrl_q};
      end else if (bus.addr == ADDR_STATUS) begin
        rdata_d = {4'h0, doneMask_q, ptr_q, state_q};
      end else if (bus.addr == ADDR_OUTS) begin
        rdata_d = {12'h000, spOut_q};
      end else if (bus.addr >= ADDR_CFG_BASE && bus.addr <= ADDR_CFG_LAST) begin
        rdata_d = {26'h000_0000, cfg_q[cfgIdx]};
      end else if (bus.addr >= ADDR_VAL_BASE && bus.addr <= ADDR_VAL_LAST) begin
        rdata_d = val_q[valIdx];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spOut_q       <= '0;
      batchActive_q <= 1'b0;
      rdata_q       <= 32'h0000_0000;
    end else begin
      spOut_q       <= spOut_d;
      batchActive_q <= (state_d == ST_RUN);
      rdata_q       <= rdata_d;
    end
  end

  assign spOut       = spOut_q;
  assign batchActive = batchActive_q;
  assign rdata       = rdata_q;

endmodule

// [verilog/sbs_pkg.sv]
package sbs_pkg;

  localparam int NSP = 20;
  localparam int AW  = 7;

  // register map, word addressed
  localparam logic [AW-1:0] ADDR_CTRL     = 7'h00;
  localparam logic [AW-1:0] ADDR_CMD      = 7'h01;
  localparam logic [AW-1:0] ADDR_STATUS   = 7'h02;
  localparam logic [AW-1:0] ADDR_OUTS     = 7'h03;
  localparam logic [AW-1:0] ADDR_CFG_BASE = 7'h20;
  localparam logic [AW-1:0] ADDR_CFG_LAST = 7'h33;
  localparam logic [AW-1:0] ADDR_VAL_BASE = 7'h40;
  localparam logic [AW-1:0] ADDR_VAL_LAST = 7'h53;

  // control register bits
  localparam int CTRL_BATCH_BIT  = 0;
  localparam int CTRL_PLC_BIT    = 1;
  localparam int CTRL_RUNASG_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // command register bits, write-one pulses
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_RESET_BIT = 2;

  localparam logic [31:0] VAL_RST = 32'h0000_0000;
  localparam int PCT_SCALE = 100;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TENTH_NS      = 100_000_000;
  localparam int TENTH_CYC     = TENTH_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    KIND_OFF, KIND_RATE, KIND_PRATE, KIND_LOAD, KIND_SPEED,
    KIND_TOTAL, KIND_CELL_MV, KIND_PAUSE, KIND_DELAY
  } sbs_kind_t;

  typedef struct packed {
    logic      batchSeq;
    logic      tripHigher;
    sbs_kind_t kind;
  } sbs_cfg_t;

  localparam sbs_cfg_t CFG_RST = '{batchSeq: 1'b0, tripHigher: 1'b0, kind: KIND_OFF};

  typedef struct packed {
    logic [31:0] rate;
    logic [31:0] load;
    logic [31:0] speed;
    logic [31:0] total;
    logic [31:0] cell_millivolt_kind;
    logic [31:0] maxCap;
  } sbs_meas_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } sbs_bus_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSED, ST_STOPPED, ST_DONE} sbs_state_t;

endpackage

// [verilog/sbs_compare.sv]
`timescale 1ns/1ps
module sbs_compare import sbs_pkg::*; (
  input  sbs_cfg_t    cfg,
  input  wire logic [31:0] value,
  input  sbs_meas_t   meas,
  output logic        hit
);

  logic [63:0] lhs;
  logic [63:0] rhs;
  logic        isCmp;

  always_comb begin
    rhs   = {32'h0000_0000, value};
    lhs   = 64'h0000_0000_0000_0000;
    isCmp = 1'b1;
    case (cfg.kind)
      KIND_RATE:   lhs = {32'h0000_0000, meas.rate};
      KIND_PRATE: begin
        // scale both sides so the percentage of capacity needs no divider
        lhs = 64'(meas.rate) * 64'(PCT_SCALE);
        rhs = 64'(value) * 64'(meas.maxCap);
      end
      KIND_LOAD:   lhs = {32'h0000_0000, meas.load};
      KIND_SPEED:  lhs = {32'h0000_0000, meas.speed};
      KIND_TOTAL:  lhs = {32'h0000_0000, meas.total};
      KIND_CELL_MV: lhs = {32'h0000_0000, meas.cell_millivolt_kind};
      default:     isCmp = 1'b0;
    endcase
    hit = isCmp && (cfg.tripHigher ? (lhs > rhs) : (lhs < rhs));
  end

endmodule

// [verilog/sbs_delay.sv]
`timescale 1ns/1ps
module sbs_delay import sbs_pkg::*; #(
  parameter int unsigned TICK_CYC = TENTH_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clear,
  input  wire logic        run,
  input  wire logic [31:0] tenths,
  output logic             done
);

  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  assign done = run && (cnt_q >= tenths);

  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (clear || !run) begin
      pre_d = 32'h0000_0000;
      cnt_d = 32'h0000_0000;
    end else if (!done) begin
      if (pre_q == 32'(TICK_CYC - 1)) begin
        pre_d = 32'h0000_0000;
        cnt_d = cnt_q + 32'h0000_0001;
      end else begin
        pre_d = pre_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 32'h0000_0000;
      cnt_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// [tb/sbs_sequencer_monitor.sv]
`timescale 1ns/1ps
module sbs_sequencer_monitor import sbs_pkg::*; (
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  sbs_bus_t            bus,
  input  wire logic [31:0]    rdata,
  input  wire logic           measUpdate,
  input  wire logic           batchStartSignal_n,
  input  wire logic           batchRunEnable_n,
  input  wire logic [NSP-1:0] spOut,
  input  wire logic           batchActive
);
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [3:0] startAgo_q;
  logic [3:0] startAgo_d;

  // mirror of the control register, rebuilt from the writes the block sees
  always_comb begin
    ctrl_d     = ctrl_q;
    startAgo_d = (startAgo_q == 4'hf) ? startAgo_q : startAgo_q + 4'h1;
    if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrl_d = bus.wdata[2:0];
    end
    // a pin start acts only after the synchroniser, hence the window below
    if ((bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_START_BIT]) || !batchStartSignal_n) begin
      startAgo_d = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q     <= CTRL_RST;
      startAgo_q <= 4'hf;
    end else begin
      ctrl_q     <= ctrl_d;
      startAgo_q <= startAgo_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0000_0000) else $error("rdata not zero");
  a_unmapped_zero: assert property (bus.rd && bus.addr == 7'h10 |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (bus.wr && bus.addr == ADDR_CTRL ##2 bus.rd && bus.addr == ADDR_CTRL
    |=> rdata[2:0] == $past(bus.wdata[2:0], 3)) else $error("control readback wrong");
  a_sp20_gone: assert property (ctrl_q[CTRL_PLC_BIT] && $past(ctrl_q[CTRL_PLC_BIT])
    && $past(ctrl_q[CTRL_PLC_BIT], 2) |-> !spOut[NSP-1]) else $error("setpoint twenty active");
  a_batch_mode_off: assert property ((!ctrl_q[CTRL_BATCH_BIT])[*3] |-> !batchActive)
    else $error("batch active while batching off");
  a_free_hold: assert property (!ctrl_q[CTRL_BATCH_BIT] && $past(!ctrl_q[CTRL_BATCH_BIT])
    && !$past(measUpdate) && !$past(bus.wr) && !$past(bus.wr, 2) |-> $stable(spOut))
    else $error("free output moved without update");
  a_stop_drops: assert property (bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_STOP_BIT]
    |-> ##2 !batchActive) else $error("stop did not halt batch");
  a_run_high_stop: assert property ((ctrl_q[CTRL_RUNASG_BIT] && batchRunEnable_n)[*6] |-> !batchActive)
    else $error("batch runs with run input high");
  a_start_needed: assert property ($rose(batchActive) |-> startAgo_q <= 4'h6)
    else $error("batch began without start");
  a_reset_idles: assert property (bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_RESET_BIT]
    |=> !batchActive) else $error("reset left batch running");
endmodule
bind sbs_sequencer sbs_sequencer_monitor u_mon (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
  .measUpdate(measUpdate), .batchStartSignal_n(batchStartSignal_n), .batchRunEnable_n(batchRunEnable_n),
  .spOut(spOut), .batchActive(batchActive));

// [tb/sbs_plant_model.sv]
`timescale 1ns/1ps
module sbs_plant_model (
  input  wire logic       clk,
  input  wire logic [2:0] press,
  input  wire logic       runHigh,
  output logic [2:0]      pin_n,
  output logic            runPin_n
);
  int hold[3];
  // contacts are pulled up, so a released switch reads high
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (press[i]) hold[i] <= 4;
      else if (hold[i] > 0) hold[i] <= hold[i] - 1;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) pin_n[i] = (hold[i] == 0);
    runPin_n = runHigh;
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench import sbs_pkg::*; ;
  logic clk = 0, arst_n = 0, measUpdate = 0, runHigh = 0, batchActive, runPin_n;
  logic [2:0] press = 3'h0, pin_n;
  sbs_bus_t bus = '0;
  sbs_meas_t meas = '0;
  logic [31:0] rdata, d, rnd = 32'h69d7_21fe;
  logic [NSP-1:0] spOut, fx, bx = 20'h0_0000;
  int kd[20], hi[20], bs[20], vl[20], numErrors = 0, checked = 0, cyc = 0, n;
  longint mr, ml, ms, mt, mc, mx;
  bit bm, plc;
  sbs_sequencer #(.TENTH_CYCLES(4)) dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .meas(meas),
    .measUpdate(measUpdate), .batchStartSignal_n(pin_n[0]), .batchRunEnable_n(runPin_n),
    .batchStopInput_n(pin_n[1]), .batchResetInput_n(pin_n[2]), .spOut(spOut), .batchActive(batchActive));
  sbs_plant_model plant (.clk(clk), .press(press), .runHigh(runHigh), .pin_n(pin_n), .runPin_n(runPin_n));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checked %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chkReg(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkOut();
    checked++;
    if ((fx | bx) !== spOut) begin
      numErrors++;
      $display("mismatch spOut expected %h seen %h", fx | bx, spOut);
    end
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] sv(int dn, int p, int s);
    return {4'h0, 20'(dn), 5'(p), 3'(s)};
  endfunction
  function automatic bit hitm(int i);
    longint a, b;
    b = vl[i];
    case (kd[i])
      1: a = mr;
      2: begin a = mr * 100; b = vl[i] * mx; end
      3: a = ml;
      4: a = ms;
      5: a = mt;
      6: a = mc;
      default: return 0;
    endcase
    return hi[i] ? a > b : a < b;
  endfunction
  task automatic wr(logic [6:0] a, logic [31:0] v);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [6:0] a, output logic [31:0] v);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic cfg(int i, int k, int h, int b, int v);
    wr(ADDR_CFG_BASE + 7'(i), {26'h0, 1'(b), 1'(h), 4'(k)});
    wr(ADDR_VAL_BASE + 7'(i), 32'(v));
    kd[i] = k; hi[i] = h; bs[i] = b; vl[i] = v;
  endtask
  task automatic measure();
    meas <= {32'(mr), 32'(ml), 32'(ms), 32'(mt), 32'(mc), 32'(mx)};
    measUpdate <= 1'b1;
    @(posedge clk);
    measUpdate <= 1'b0;
    repeat (2) @(posedge clk);
    // compare kinds only; pause and delay never drive a free output
    for (int i = 0; i < 20; i++) fx[i] = kd[i] inside {[1:6]} && !(bs[i] && bm) && !(i == 19 && plc) && hitm(i);
    @(negedge clk);
    chkOut();
    @(posedge clk);
  endtask
  task automatic pin(int k);
    press[k] <= 1'b1;
    @(posedge clk);
    press[k] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic status(int dn, int p, int s, logic [31:0] m);
    @(negedge clk);
    chkReg("active", 32'(s == 1), {31'h0000_0000, batchActive});
    @(posedge clk);
    rd(ADDR_STATUS, d);
    chkReg("status", sv(dn, p, s) & m, d & m);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, d); chkReg("ctrl", 32'h0000_0000, d);
    rd(7'h10, d); chkReg("unmapped", 32'h0000_0000, d);
    rd(ADDR_CMD, d); chkReg("cmd", 32'h0000_0000, d);
    cfg(5, 9, 0, 0, 0);
    rd(ADDR_CFG_BASE + 7'h05, d); chkReg("badkind", 32'h0000_0000, d);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      cfg(i, i + 1, i % 2, 0, int'(rnd[11:0]));
    end
    cfg(19, 1, 1, 0, 0);
    rd(ADDR_VAL_BASE + 7'h03, d);
    chkReg("value", 32'(vl[3]), d);
    for (int t = 0; t < 14; t++) begin
      rnd = lfsr(rnd); mr = rnd[11:0]; ml = rnd[23:12];
      rnd = lfsr(rnd); ms = rnd[11:0]; mt = rnd[23:12];
      rnd = lfsr(rnd); mc = rnd[11:0]; mx = rnd[23:12] | 1;
      if (t == 10) begin
        plc = 1;
        wr(ADDR_CTRL, 32'h0000_0002);
        rd(ADDR_CTRL, d); chkReg("ctrl", 32'h0000_0002, d);
      end
      measure();
    end
    bm = 1;
    wr(ADDR_CTRL, 32'h0000_0003);
    cfg(6, 1, 1, 1, 100); cfg(7, 7, 0, 0, 0); cfg(8, 8, 0, 0, 2); cfg(9, 3, 1, 1, 100);
    rd(ADDR_CFG_BASE + 7'h06, d);
    chkReg("cfg", 32'h0000_0031, d);
    mr = 50; ml = 50;
    measure();
    wr(ADDR_CMD, 32'h0000_0001);
    bx = 20'h0_0040;
    status(0, 6, 1, '1);
    measure();
    mr = 150; bx = 0;
    measure();
    status(32'h40, 7, 2, '1);
    pin(0);
    n = 0;
    do rd(ADDR_STATUS, d); while (d[7:3] != 9 && ++n < 40);
    status(32'h40, 9, 1, '1);
    bx = 20'h0_0200;
    @(negedge clk); chkOut();
    @(posedge clk);
    rd(ADDR_OUTS, d);
    chkReg("outs", 32'(fx | bx), d);
    pin(1); bx = 0;
    status(32'h40, 9, 3, '1);
    @(negedge clk); chkOut();
    @(posedge clk);
    wr(ADDR_CTRL, 32'h0000_0007);
    runHigh <= 1'b1;
    // the run pin needs the synchroniser's edges before a start can see it
    repeat (3) @(posedge clk);
    wr(ADDR_CMD, 32'h0000_0001);
    status(0, 6, 0, 32'h0000_00ff);
    runHigh <= 1'b0;
    repeat (5) @(posedge clk);
    wr(ADDR_CMD, 32'h0000_0001);
    status(0, 6, 1, '1);
    runHigh <= 1'b1;
    repeat (8) @(posedge clk);
    status(0, 6, 3, 32'h0000_00ff);
    runHigh <= 1'b0;
    repeat (5) @(posedge clk);
    wr(ADDR_CMD, 32'h0000_0001);
    measure();
    status(32'h40, 7, 2, '1);
    pin(2);
    status(0, 6, 0, 32'h0000_00ff);
    wr(ADDR_CMD, 32'h0000_0001);
    measure();
    bus.addr <= ADDR_CMD;
    bus.wdata <= 32'h0000_0001;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    n = 0;
    while (!spOut[9] && n < 50) begin
      @(negedge clk);
      n++;
    end
    chkReg("delay", 32'h0000_0001, 32'((n >= 8) && (n <= 13)));
    @(posedge clk);
    ml = 150; bx = 0;
    measure();
    status(32'h240, 0, 4, 32'hffff_ff07);
    wr(ADDR_CMD, 32'h0000_0002);
    wr(ADDR_CMD, 32'h0000_0004);
    status(0, 6, 0, 32'h0000_00ff);
    bm = 0;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0001);
    status(0, 0, 0, 32'h0000_0007);
    stop_test();
  end
endmodule
